// ===== i2c_cfg_pkg.sv
package i2c_cfg_pkg;

    // ****************************************************************
    // slave address and subaddress layout
    // ****************************************************************
    // 7-bit main map address; addr_select_pin replaces its bit 0
    localparam logic [6:0] MAIN_ADDR_BASE        = 7'h20;
    localparam logic [7:0] SUBMAP_SELECT_OFFSET  = 8'h0E;
    localparam logic [7:0] CONTRAST_BOOST_OFFSET = 8'h80;
    localparam logic [7:0] PP_ADDR_OFFSET        = 8'hFD;
    localparam logic [7:0] CSI_ADDR_OFFSET       = 8'hFE;
    // highest valid subaddress of every sub map
    localparam logic [7:0] LAST_SUBADDR          = 8'hFE;

    // ****************************************************************
    // field positions and values after reset
    // ****************************************************************
    localparam int         SEL_FIELD_LSB         = 5;
    localparam int         SEL_FIELD_MSB         = 6;
    localparam int         CONTRAST_ENABLE_BIT   = 7;
    localparam logic [7:0] SUBMAP_SELECT_RESET   = 8'h00;
    localparam logic [7:0] CONTRAST_BOOST_RESET  = 8'h00;
    localparam logic [7:0] PP_ADDR_RESET         = 8'h00;
    localparam logic [7:0] CSI_ADDR_RESET        = 8'h00;

    // ****************************************************************
    // sizes and counts
    // ****************************************************************
    localparam logic [3:0] BITS_PER_BYTE         = 4'h8;
    localparam int         MEM_ADDR_W            = 10;
    localparam int         MEM_DEPTH             = 768;

    // ****************************************************************
    // enumerations
    // ****************************************************************
    typedef enum logic [1:0] {
        MAP_USER     = 2'b00,
        MAP_INTR_VBI = 2'b01,
        MAP_USER2    = 2'b10
    } submap_t;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_ADDR      = 4'b0001,
        ST_ADDR_ACK  = 4'b0010,
        ST_SUB       = 4'b0011,
        ST_SUB_ACK   = 4'b0100,
        ST_WDATA     = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA     = 4'b0111,
        ST_RDATA_ACK = 4'b1000
    } port_state_t;

endpackage

// ===== regmem_if.sv
`timescale 1ns/10ps

interface regmem_if;
    logic                                 we;
    logic [i2c_cfg_pkg::MEM_ADDR_W-1:0]   waddr;
    logic [7:0]                           wdata;
    logic [i2c_cfg_pkg::MEM_ADDR_W-1:0]   raddr;
    logic [7:0]                           rdata;

    modport port (
        output we,
        output waddr,
        output wdata,
        output raddr,
        input  rdata
    );

    modport mem (
        input  we,
        input  waddr,
        input  wdata,
        input  raddr,
        output rdata
    );
endinterface

// ===== regmem.sv
`timescale 1ns/10ps

module regmem (
    input  wire logic ref_clk,
    regmem_if.mem     bus
);

    // ****************************************************************
    // backing store for all three sub maps, one page of 256 each
    // ****************************************************************
    // plain array rather than a struct: the store is far too big for one
    logic [7:0] store [0:i2c_cfg_pkg::MEM_DEPTH-1];
    logic [7:0] rdata_q;

    // no reset on the store: contents after reset are undefined
    always_ff @(posedge ref_clk) begin
        if (bus.we) begin
            store[bus.waddr] <= bus.wdata;
        end
        rdata_q <= store[bus.raddr];
    end

    assign bus.rdata = rdata_q;

endmodule

// ===== i2c_config_slave_port.sv
`timescale 1ns/10ps

// Function
// - pin sets address bit 1: 0x40/0x42
// - first byte bit 0 gives direction
// - eight address bits sampled, MSB first
// - own address acknowledged on ninth pulse
// - other address: release bus, stay idle
// - byte one address, byte two subaddress
// - subaddress advances after every acknowledged data byte below the top
// - single registers reachable on their own
// - start/stop anywhere; stray stop goes idle, stray start restarts addressing
// - invalid subaddress: no acknowledge, go idle
// - read past top repeats highest register
// - data high on ninth pulse is no-ack
// - write past top: discard, no-ack, idle
// - select field at 0x0E[6:5] picks sub map
// - main map holds two programmable slave addresses
// - contrast boost off after reset
// - select codes 00 user, 01 irq, 10 user2

module i2c_config_slave_port (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       serial_clock_pin,
    input  wire logic       serial_data_pin_in,
    output logic            serial_data_pin_out,
    output logic            serial_data_pin_oe,
    input  wire logic       addr_select_pin,
    output logic [1:0]      submap_select,
    output logic            contrast_boost,
    output logic [7:0]      pp_slave_addr,
    output logic [7:0]      csi_slave_addr
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic                                 scl_s1;
        logic                                 scl_s2;
        logic                                 scl_p;
        logic                                 sda_s1;
        logic                                 sda_s2;
        logic                                 sda_p;
        logic                                 pin_s1;
        logic                                 pin_s2;
        i2c_cfg_pkg::port_state_t             state;
        logic [3:0]                           bitcnt;
        logic [7:0]                           shreg;
        logic                                 rw;
        logic [7:0]                           ptr;
        logic                                 ovf;
        logic                                 oe;
        logic                                 dout;
        logic [7:0]                           sel;
        logic [7:0]                           boost;
        logic [7:0]                           pp_addr;
        logic [7:0]                           csi_addr;
        logic                                 mem_we;
        logic [i2c_cfg_pkg::MEM_ADDR_W-1:0]   mem_wa;
        logic [7:0]                           mem_wd;
    } port_regs_t;

    port_regs_t q;
    port_regs_t d;

    regmem_if mif ();

    regmem u_regmem (
        .ref_clk (ref_clk),
        .bus     (mif)
    );

    // ****************************************************************
    // bus conditions, seen only through the second sync stage
    // ****************************************************************
    logic                         scl_rise;
    logic                         scl_fall;
    logic                         start_seen;
    logic                         stop_seen;
    logic                         addr_match;
    logic                         byte_done;
    logic [1:0]                   map_idx;
    logic [7:0]                   rd_byte;
    logic [7:0]                   ptr_next;

    assign scl_rise   = q.scl_s2 & ~q.scl_p;
    assign scl_fall   = ~q.scl_s2 & q.scl_p;
    // clock high on both samples, so data moved while clock stayed high
    assign start_seen = q.scl_s2 & q.scl_p & ~q.sda_s2 & q.sda_p;
    assign stop_seen  = q.scl_s2 & q.scl_p & q.sda_s2 & ~q.sda_p;
    assign byte_done  = (q.bitcnt == i2c_cfg_pkg::BITS_PER_BYTE);
    assign ptr_next   = q.ptr + 8'h01;

    // address byte is shreg[7:1], direction in shreg[0]
    assign addr_match =
        (q.shreg[7:2] == i2c_cfg_pkg::MAIN_ADDR_BASE[6:1]) &&
        (q.shreg[1] == q.pin_s2);

    // the reserved code 11 falls back to the user page
    always_comb begin
        case (q.sel[i2c_cfg_pkg::SEL_FIELD_MSB:i2c_cfg_pkg::SEL_FIELD_LSB])
            i2c_cfg_pkg::MAP_USER:     map_idx = 2'b00;
            i2c_cfg_pkg::MAP_INTR_VBI: map_idx = 2'b01;
            i2c_cfg_pkg::MAP_USER2:    map_idx = 2'b10;
            default:                   map_idx = 2'b00;
        endcase
    end

    // memory read data is registered, so the pointer must settle at
    // least one cycle before a byte is loaded; the synchroniser delay
    // and the clock high time give many cycles of margin
    assign mif.raddr = {map_idx, q.ptr};
    assign rd_byte   = (q.ptr == i2c_cfg_pkg::SUBMAP_SELECT_OFFSET) ?
                       q.sel : mif.rdata;

    assign mif.we    = q.mem_we;
    assign mif.waddr = q.mem_wa;
    assign mif.wdata = q.mem_wd;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        d = q;
        d.mem_we = 1'b0;
        d.dout   = 1'b0;

        d.scl_s1 = serial_clock_pin;
        d.scl_s2 = q.scl_s1;
        d.scl_p  = q.scl_s2;
        d.sda_s1 = serial_data_pin_in;
        d.sda_s2 = q.sda_s1;
        d.sda_p  = q.sda_s2;
        d.pin_s1 = addr_select_pin;
        d.pin_s2 = q.pin_s1;

        if (stop_seen) begin
            // a stop anywhere ends the transfer and frees the line
            d.state  = i2c_cfg_pkg::ST_IDLE;
            d.oe     = 1'b0;
            d.bitcnt = 4'h0;
        end else if (start_seen) begin
            // a start anywhere, repeated or stray, restarts addressing
            d.state  = i2c_cfg_pkg::ST_ADDR;
            d.oe     = 1'b0;
            d.bitcnt = 4'h0;
        end else if (scl_rise) begin
            case (q.state)
                i2c_cfg_pkg::ST_ADDR,
                i2c_cfg_pkg::ST_SUB,
                i2c_cfg_pkg::ST_WDATA: begin
                    d.shreg  = {q.shreg[6:0], q.sda_s2};
                    d.bitcnt = q.bitcnt + 4'h1;
                end
                i2c_cfg_pkg::ST_RDATA: begin
                    d.shreg  = {q.shreg[6:0], 1'b0};
                    d.bitcnt = q.bitcnt + 4'h1;
                end
                i2c_cfg_pkg::ST_RDATA_ACK: begin
                    if (q.sda_s2) begin
                        // master left data high: end of read
                        d.state = i2c_cfg_pkg::ST_IDLE;
                    end else if (q.ptr != i2c_cfg_pkg::LAST_SUBADDR) begin
                        d.ptr = ptr_next;
                    end
                    // at the top the pointer holds, so it repeats
                end
                default: begin
                    d.bitcnt = q.bitcnt;
                end
            endcase
        end else if (scl_fall) begin
            case (q.state)
                i2c_cfg_pkg::ST_ADDR: begin
                    if (byte_done) begin
                        d.bitcnt = 4'h0;
                        if (addr_match) begin
                            d.rw    = q.shreg[0];
                            d.oe    = 1'b1;
                            d.state = i2c_cfg_pkg::ST_ADDR_ACK;
                        end else begin
                            d.oe    = 1'b0;
                            d.state = i2c_cfg_pkg::ST_IDLE;
                        end
                    end
                end
                i2c_cfg_pkg::ST_ADDR_ACK: begin
                    d.bitcnt = 4'h0;
                    if (q.rw) begin
                        // reads start at the pointer left by the
                        // last transfer, write or read
                        d.shreg = rd_byte;
                        d.oe    = ~rd_byte[7];
                        d.state = i2c_cfg_pkg::ST_RDATA;
                    end else begin
                        d.oe    = 1'b0;
                        d.state = i2c_cfg_pkg::ST_SUB;
                    end
                end
                i2c_cfg_pkg::ST_SUB: begin
                    if (byte_done) begin
                        d.bitcnt = 4'h0;
                        if (q.shreg > i2c_cfg_pkg::LAST_SUBADDR) begin
                            d.oe    = 1'b0;
                            d.state = i2c_cfg_pkg::ST_IDLE;
                        end else begin
                            d.ptr   = q.shreg;
                            d.ovf   = 1'b0;
                            d.oe    = 1'b1;
                            d.state = i2c_cfg_pkg::ST_SUB_ACK;
                        end
                    end
                end
                i2c_cfg_pkg::ST_SUB_ACK,
                i2c_cfg_pkg::ST_WDATA_ACK: begin
                    d.oe     = 1'b0;
                    d.bitcnt = 4'h0;
                    d.state  = i2c_cfg_pkg::ST_WDATA;
                end
                i2c_cfg_pkg::ST_WDATA: begin
                    if (byte_done) begin
                        d.bitcnt = 4'h0;
                        if (q.ovf) begin
                            // past the top: byte dropped, no ack
                            d.oe    = 1'b0;
                            d.state = i2c_cfg_pkg::ST_IDLE;
                        end else begin
                            d.oe    = 1'b1;
                            d.state = i2c_cfg_pkg::ST_WDATA_ACK;
                            // each byte lands alone at its own address
                            d.mem_we = 1'b1;
                            d.mem_wa = {map_idx, q.ptr};
                            d.mem_wd = q.shreg;
                            if (q.ptr ==
                                i2c_cfg_pkg::SUBMAP_SELECT_OFFSET) begin
                                d.sel = q.shreg;
                            end
                            if (map_idx == i2c_cfg_pkg::MAP_USER &&
                                q.ptr == i2c_cfg_pkg::PP_ADDR_OFFSET) begin
                                d.pp_addr = q.shreg;
                            end
                            if (map_idx == i2c_cfg_pkg::MAP_USER &&
                                q.ptr == i2c_cfg_pkg::CSI_ADDR_OFFSET) begin
                                d.csi_addr = q.shreg;
                            end
                            if (map_idx == i2c_cfg_pkg::MAP_USER2 &&
                                q.ptr ==
                                i2c_cfg_pkg::CONTRAST_BOOST_OFFSET) begin
                                d.boost = q.shreg;
                            end
                            if (q.ptr == i2c_cfg_pkg::LAST_SUBADDR) begin
                                d.ovf = 1'b1;
                            end else begin
                                d.ptr = ptr_next;
                            end
                        end
                    end
                end
                i2c_cfg_pkg::ST_RDATA: begin
                    if (byte_done) begin
                        d.bitcnt = 4'h0;
                        d.oe     = 1'b0;
                        d.state  = i2c_cfg_pkg::ST_RDATA_ACK;
                    end else begin
                        d.oe = ~q.shreg[7];
                    end
                end
                i2c_cfg_pkg::ST_RDATA_ACK: begin
                    // only reached after an ack; a no-ack left already
                    d.bitcnt = 4'h0;
                    d.shreg  = rd_byte;
                    d.oe     = ~rd_byte[7];
                    d.state  = i2c_cfg_pkg::ST_RDATA;
                end
                default: begin
                    d.oe    = 1'b0;
                    d.state = i2c_cfg_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            q          <= '0;
            q.scl_s1   <= 1'b1;
            q.scl_s2   <= 1'b1;
            q.scl_p    <= 1'b1;
            q.sda_s1   <= 1'b1;
            q.sda_s2   <= 1'b1;
            q.sda_p    <= 1'b1;
            q.state    <= i2c_cfg_pkg::ST_IDLE;
            q.sel      <= i2c_cfg_pkg::SUBMAP_SELECT_RESET;
            q.boost    <= i2c_cfg_pkg::CONTRAST_BOOST_RESET;
            q.pp_addr  <= i2c_cfg_pkg::PP_ADDR_RESET;
            q.csi_addr <= i2c_cfg_pkg::CSI_ADDR_RESET;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // open drain: the line is only ever pulled low
    assign serial_data_pin_out = q.dout;
    assign serial_data_pin_oe  = q.oe;
    assign submap_select       =
        q.sel[i2c_cfg_pkg::SEL_FIELD_MSB:i2c_cfg_pkg::SEL_FIELD_LSB];
    assign contrast_boost      = q.boost[i2c_cfg_pkg::CONTRAST_ENABLE_BIT];
    assign pp_slave_addr       = q.pp_addr;
    assign csi_slave_addr      = q.csi_addr;

endmodule

// ===== i2c_config_slave_port_sva.sv
`timescale 1ns/10ps

module i2c_config_slave_port_sva (
    input logic       ref_clk,
    input logic       reset_n,
    input logic       serial_clock_pin,
    input logic       serial_data_pin_in,
    input logic       serial_data_pin_out,
    input logic       serial_data_pin_oe,
    input logic       addr_select_pin,
    input logic [1:0] submap_select,
    input logic       contrast_boost,
    input logic [7:0] pp_slave_addr,
    input logic [7:0] csi_slave_addr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // ****************************************************************
    // bus watcher: bits since the last start, counted on clock rises
    // ****************************************************************
    logic       scl_q;
    logic       sda_q;
    logic [3:0] nbit_q;
    logic [7:0] addr_q;
    logic       rise;
    logic       start;
    logic       stop;
    logic       match;

    assign rise  = !scl_q && serial_clock_pin;
    assign start = scl_q && serial_clock_pin && sda_q && !serial_data_pin_in;
    assign stop  = scl_q && serial_clock_pin && !sda_q && serial_data_pin_in;
    assign match = addr_q[7:2] == 6'h10 && addr_q[1] == addr_select_pin;

    always_ff @(posedge ref_clk) begin
        scl_q <= serial_clock_pin;
        sda_q <= serial_data_pin_in;
        if (!reset_n) begin
            nbit_q <= 4'hF;
        end else if (start) begin
            nbit_q <= 4'h0;
        end else if (rise && nbit_q != 4'hF) begin
            nbit_q <= nbit_q + 4'h1;
            if (nbit_q < 4'h8) begin
                addr_q <= {addr_q[6:0], serial_data_pin_in};
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    AST_OUT_LOW: assert property (serial_data_pin_out == 1'b0)
        else $error("data pin drive value is not low");
    AST_RESET_STATE: assert property ($rose(reset_n) |->
        !serial_data_pin_oe && submap_select == 2'b00 && !contrast_boost
        && pp_slave_addr == 8'h00 && csi_slave_addr == 8'h00)
        else $error("outputs not at reset values after reset");
    AST_ADDR_ACK: assert property (rise && nbit_q == 4'h8 |->
        serial_data_pin_oe == match)
        else $error("address acknowledge does not follow address match");
    AST_ACK_CLK_LOW: assert property (
        $rose(serial_data_pin_oe) |-> !serial_clock_pin)
        else $error("data pin pulled while bus clock high");
    AST_RELEASE_CLK_LOW: assert property (
        $fell(serial_data_pin_oe) |-> !serial_clock_pin)
        else $error("data pin released while bus clock high");
    AST_STOP_IDLE: assert property (stop |=> !serial_data_pin_oe [*8])
        else $error("data pin pulled after stop");
    AST_SEL_AT_CLK_LOW: assert property (
        $changed(submap_select) |-> !serial_clock_pin)
        else $error("select field changed outside a byte end");
    AST_BOOST_IN_MAP2: assert property (
        $changed(contrast_boost) |-> submap_select == 2'b10)
        else $error("boost changed while second user map not selected");
    AST_ADDR_IN_USER: assert property (
        $changed(pp_slave_addr) || $changed(csi_slave_addr)
        |-> submap_select inside {2'b00, 2'b11})
        else $error("map address changed outside user map");

    COV_ACK: cover property (rise && nbit_q == 4'h8 && serial_data_pin_oe);
    COV_BOOST: cover property ($rose(contrast_boost));
    COV_MAP1: cover property (submap_select == 2'b01);
    COV_STOP: cover property (stop);
endmodule

bind i2c_config_slave_port i2c_config_slave_port_sva chk (
    .ref_clk             (ref_clk),
    .reset_n             (reset_n),
    .serial_clock_pin    (serial_clock_pin),
    .serial_data_pin_in  (serial_data_pin_in),
    .serial_data_pin_out (serial_data_pin_out),
    .serial_data_pin_oe  (serial_data_pin_oe),
    .addr_select_pin     (addr_select_pin),
    .submap_select       (submap_select),
    .contrast_boost      (contrast_boost),
    .pp_slave_addr       (pp_slave_addr),
    .csi_slave_addr      (csi_slave_addr)
);

// ===== i2c_master_model.sv
`timescale 1ns/10ps

module i2c_master_model #(
    parameter int HALF = 16
) (
    input  logic ref_clk,
    output logic scl,
    output logic sda_pull,
    input  logic sda
);
    // hold after each clock fall exceeds the device's 3-cycle turnaround
    localparam int HOLD = 4;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // one clock pulse; seen is the wire level in mid-high
    task automatic pulse(input logic low, output logic seen);
        sda_pull = low;
        wt(HALF);
        scl = 1'b1;
        wt(HALF / 2);
        seen = sda;
        wt(HALF / 2);
        scl = 1'b0;
        wt(HOLD);
    endtask

    task automatic start();
        if (!scl) begin
            sda_pull = 1'b0;
            wt(HALF);
            scl = 1'b1;
            wt(HALF);
        end
        sda_pull = 1'b1;
        wt(HALF);
        scl = 1'b0;
        wt(HOLD);
    endtask

    task automatic stop();
        sda_pull = 1'b1;
        wt(HALF);
        scl = 1'b1;
        wt(HALF);
        sda_pull = 1'b0;
        wt(HALF);
    endtask

    task automatic bits(input logic [7:0] b, input int n);
        logic s;
        for (int i = 7; i > 7 - n; i--) begin
            pulse(!b[i], s);
        end
    endtask

    task automatic put(input logic [7:0] b, output logic ack);
        logic s;
        bits(b, 8);
        pulse(1'b0, s);
        ack = !s;
    endtask

    task automatic get(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b0, s);
            d[i] = s;
        end
        pulse(!last, s);
        sda_pull = 1'b0;
    endtask
endmodule

// ===== i2c_config_slave_port_tb.sv
`timescale 1ns/10ps

module i2c_config_slave_port_tb;
    `define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
    end end

    logic       ref_clk;
    logic       reset_n;
    logic       scl;
    logic       sda_pull;
    logic       sda_line;
    logic       data_oe;
    logic       data_out;
    logic       addr_select_pin;
    logic [1:0] submap_select;
    logic       contrast_boost;
    logic [7:0] pp_slave_addr;
    logic [7:0] csi_slave_addr;
    logic [2:0] ak;
    logic       a;
    logic [7:0] d;
    int         n_mismatch = 0;
    int         compares = 0;
    // {subaddress, value, expected select, expected boost}
    logic [18:0] tbl [8] = '{{8'h0E, 8'h20, 3'h2}, {8'h0E, 8'h40, 3'h4},
        {8'h80, 8'h80, 3'h5}, {8'h0E, 8'h00, 3'h1}, {8'h80, 8'h00, 3'h1},
        {8'h0E, 8'h40, 3'h5}, {8'h80, 8'h00, 3'h4}, {8'h0E, 8'h00, 3'h0}};

    // wire has a pull-up; either party may pull it low
    assign sda_line = !(sda_pull || (data_oe && !data_out));

    i2c_config_slave_port dut (
        .ref_clk             (ref_clk),
        .reset_n             (reset_n),
        .serial_clock_pin    (scl),
        .serial_data_pin_in  (sda_line),
        .serial_data_pin_out (data_out),
        .serial_data_pin_oe  (data_oe),
        .addr_select_pin     (addr_select_pin),
        .submap_select       (submap_select),
        .contrast_boost      (contrast_boost),
        .pp_slave_addr       (pp_slave_addr),
        .csi_slave_addr      (csi_slave_addr)
    );

    i2c_master_model mdl (
        .ref_clk  (ref_clk),
        .scl      (scl),
        .sda_pull (sda_pull),
        .sda      (sda_line)
    );

    // ****************************************************************
    // bus tasks
    // ****************************************************************
    task automatic wr(input logic [7:0] dev, sub, val,
                      output logic [2:0] acks);
        mdl.start();
        mdl.put(dev, acks[2]);
        mdl.put(sub, acks[1]);
        mdl.put(val, acks[0]);
        mdl.stop();
    endtask

    task automatic finish_test();
        if (n_mismatch == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        n_mismatch++;
        finish_test();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        reset_n = 1'b0;
        addr_select_pin = 1'b0;
        repeat (2) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        `CHK("sel_reset", 2'b00, submap_select)
        `CHK("boost_reset", 1'b0, contrast_boost)
        `CHK("pp_reset", 8'h00, pp_slave_addr)
        `CHK("csi_reset", 8'h00, csi_slave_addr)
        wr(8'h44, 8'h0E, 8'h20, ak);
        `CHK("ack_foreign", 3'b000, ak)
        `CHK("sel_foreign", 2'b00, submap_select)
        // select walks the three maps; 0x80 writes change the boost only in user2
        foreach (tbl[i]) begin
            wr(8'h40, tbl[i][18:11], tbl[i][10:3], ak);
            `CHK("ack_seq", 3'b111, ak)
            `CHK("sel_seq", tbl[i][2:1], submap_select)
            `CHK("boost_seq", tbl[i][0], contrast_boost)
        end
        mdl.start();
        mdl.put(8'h40, a);
        mdl.put(8'hFD, a);
        mdl.put(8'h84, a);
        mdl.put(8'h88, a);
        `CHK("ack_csi", 1'b1, a)
        mdl.put(8'h55, a);
        `CHK("ack_past_top", 1'b0, a)
        mdl.stop();
        `CHK("pp_addr", 8'h84, pp_slave_addr)
        `CHK("csi_addr", 8'h88, csi_slave_addr)
        mdl.start();
        mdl.put(8'h40, a);
        mdl.put(8'hFD, a);
        mdl.start();
        mdl.put(8'h41, a);
        `CHK("ack_read", 1'b1, a)
        mdl.get(1'b0, d);
        `CHK("rd_first", 8'h84, d)
        mdl.get(1'b0, d);
        `CHK("rd_next", 8'h88, d)
        mdl.get(1'b1, d);
        `CHK("rd_top", 8'h88, d)
        mdl.stop();
        mdl.start();
        mdl.put(8'h40, a);
        mdl.put(8'hFF, a);
        `CHK("ack_bad_sub", 1'b0, a)
        mdl.put(8'h20, a);
        `CHK("ack_after_bad", 1'b0, a)
        mdl.stop();
        mdl.start();
        mdl.put(8'h40, a);
        mdl.put(8'h0E, a);
        mdl.bits(8'h20, 4);
        mdl.stop();
        `CHK("sel_stray_stop", 2'b00, submap_select)
        addr_select_pin = 1'b1;
        repeat (8) @(negedge ref_clk);
        wr(8'h40, 8'h0E, 8'h20, ak);
        `CHK("ack_pin_low_addr", 3'b000, ak)
        wr(8'h42, 8'h0E, 8'h20, ak);
        `CHK("ack_pin_high_addr", 3'b111, ak)
        `CHK("sel_pin_high", 2'b01, submap_select)
        finish_test();
    end
endmodule
